//--- btt_target.sv
`timescale 1ns/10ps
`default_nettype none

module btt_target
  import btt_pkg::*;
(
  input  wire logic      sys_clk_in,
  input  wire logic      rst_in,
  input  wire logic      frame_n_in,
  input  wire logic      irdy_n_in,
  input  wire logic      claim_in,
  input  wire logic      read_in,
  input  wire logic      resp_valid_in,
  input  wire btt_resp_t resp_kind_in,
  output var  logic      devsel_n_out,
  output var  logic      devsel_oe_n_out,
  output var  logic      trdy_n_out,
  output var  logic      trdy_oe_n_out,
  output var  logic      stop_n_out,
  output var  logic      stop_oe_n_out,
  output var  logic      resp_ready_out,
  output var  logic      xfer_out,
  output var  logic      phase_done_out,
  output var  logic      end_valid_out,
  output var  btt_end_t  end_kind_out,
  output var  logic      abnormal_out
);

  btt_state_t state;
  btt_state_t next_state;
  btt_drive_t drv;
  btt_drive_t next_drv;
  logic       drive_n;
  logic       next_drive_n;
  logic       resp_ready;
  logic       next_resp_ready;
  logic       xfer;
  logic       next_xfer;
  logic       phase_done_q;
  logic       next_phase_done_q;
  logic       end_valid;
  logic       next_end_valid;
  btt_end_t   end_kind;
  btt_end_t   next_end_kind;
  logic       abnormal;
  logic       next_abnormal;
  logic       moved;
  logic       next_moved;
  logic       first;
  logic       next_first;

  logic       phase_done;
  logic       data_moved;
  logic       last_done;
  logic       take;
  btt_end_t   ending;

  btt_phase_mon u_mon (
    .frame_n_in (frame_n_in),
    .irdy_n_in  (irdy_n_in),
    .trdy_n_in  (drv.trdy_n),
    .stop_n_in  (drv.stop_n),
    .done_out   (phase_done),
    .xfer_out   (data_moved),
    .last_out   (last_done)
  );

  // map a back-end answer onto the pin commitment
  function automatic btt_drive_t encode(input btt_resp_t kind);
    btt_drive_t d;
    d = '{devsel_n: BTT_ON, trdy_n: BTT_OFF, stop_n: BTT_OFF};
    case (kind)
      BTT_RESP_CONT: begin
        d.trdy_n = BTT_ON;
      end
      BTT_RESP_DISC_DATA: begin
        d.trdy_n = BTT_ON;
        d.stop_n = BTT_ON;
      end
      BTT_RESP_STOP: begin
        d.stop_n = BTT_ON;
      end
      BTT_RESP_ABORT: begin
        d.devsel_n = BTT_OFF;
        d.stop_n   = BTT_ON;
      end
      default: begin
        d = BTT_DRIVE_IDLE;
      end
    endcase
    return d;
  endfunction

  // how the transaction ended, judged on its last completing phase and on data moved in earlier phases
  always_comb begin
    if (drv.devsel_n) begin
      ending = BTT_END_ABORT;
    end else if (drv.stop_n) begin
      ending = BTT_END_NORMAL;
    end else if (first && data_moved) begin
      // single phase with trdy and stop is a plain completion
      ending = BTT_END_NORMAL;
    end else if (moved || data_moved) begin
      ending = BTT_END_DISC;
    end else begin
      ending = BTT_END_RETRY;
    end
  end

  always_comb begin
    next_state        = state;
    next_drv          = drv;
    next_drive_n      = drive_n;
    next_xfer         = data_moved;
    next_phase_done_q = phase_done;
    next_end_valid    = 1'b0;
    next_end_kind     = end_kind;
    next_abnormal     = 1'b0;
    next_moved        = moved;
    next_first        = first;
    take              = 1'b0;
    case (state)
      BTT_IDLE: begin
        if (claim_in) begin
          next_drive_n     = BTT_ON;
          next_drv         = BTT_DRIVE_IDLE;
          next_drv.devsel_n = BTT_ON;
          next_moved       = 1'b0;
          next_first       = 1'b1;
          if (read_in) begin
            // turnaround: devsel only, stop must stay off
            next_state = BTT_TURN;
          end else if (resp_valid_in && resp_kind_in != BTT_RESP_ABORT) begin
            // fast claim: devsel, trdy and stop together
            take       = 1'b1;
            next_drv   = encode(resp_kind_in);
            next_state = BTT_COMMIT;
          end else begin
            next_state = BTT_WAIT;
          end
        end
      end
      BTT_TURN: begin
        next_state = BTT_WAIT;
      end
      BTT_WAIT: begin
        // no commitment yet: trdy and stop both off
        // stop only appears with the answer that completes
        if (resp_valid_in) begin
          take       = 1'b1;
          next_drv   = encode(resp_kind_in);
          next_state = BTT_COMMIT;
        end
      end
      BTT_COMMIT: begin
        // drive stays frozen until the phase completes
        if (phase_done) begin
          next_first = 1'b0;
          if (data_moved) begin
            next_moved = 1'b1;
          end
          if (last_done) begin
            next_drv       = BTT_DRIVE_IDLE;
            next_state     = BTT_RELEASE;
            next_end_valid = 1'b1;
            next_end_kind  = ending;
            next_abnormal  = (ending == BTT_END_ABORT);
          end else if (!drv.stop_n) begin
            // master goes on: drop trdy, keep stop
            next_drv.trdy_n = BTT_OFF;
            next_state      = BTT_STOPPING;
          end else begin
            next_drv.trdy_n = BTT_OFF;
            next_state      = BTT_WAIT;
          end
        end
      end
      BTT_STOPPING: begin
        // stop held through any number of master phases
        if (last_done) begin
          next_drv       = BTT_DRIVE_IDLE;
          next_state     = BTT_RELEASE;
          next_end_valid = 1'b1;
          next_end_kind  = ending;
          next_abnormal  = (ending == BTT_END_ABORT);
        end
      end
      BTT_RELEASE: begin
        // one cycle driven high, then float; idle even after abort
        next_drive_n = BTT_OFF;
        next_state   = BTT_IDLE;
      end
      default: begin
        next_state   = BTT_IDLE;
        next_drv     = BTT_DRIVE_IDLE;
        next_drive_n = BTT_OFF;
      end
    endcase
    next_resp_ready = (next_state == BTT_WAIT);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state        <= BTT_IDLE;
      drv          <= BTT_DRIVE_IDLE;
      drive_n      <= BTT_OFF;
      resp_ready   <= 1'b0;
      xfer         <= 1'b0;
      phase_done_q <= 1'b0;
      end_valid    <= 1'b0;
      end_kind     <= BTT_END_NORMAL;
      abnormal     <= 1'b0;
      moved        <= 1'b0;
      first        <= 1'b0;
    end else begin
      state        <= next_state;
      drv          <= next_drv;
      drive_n      <= next_drive_n;
      resp_ready   <= next_resp_ready;
      xfer         <= next_xfer;
      phase_done_q <= next_phase_done_q;
      end_valid    <= next_end_valid;
      end_kind     <= next_end_kind;
      abnormal     <= next_abnormal;
      moved        <= next_moved;
      first        <= next_first;
    end
  end

  assign devsel_n_out    = drv.devsel_n;
  assign trdy_n_out      = drv.trdy_n;
  assign stop_n_out      = drv.stop_n;
  assign devsel_oe_n_out = drive_n;
  assign trdy_oe_n_out   = drive_n;
  assign stop_oe_n_out   = drive_n;
  assign resp_ready_out  = resp_ready;
  assign xfer_out        = xfer;
  assign phase_done_out  = phase_done_q;
  assign end_valid_out   = end_valid;
  assign end_kind_out    = end_kind;
  assign abnormal_out    = abnormal;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  chk_phase_report: assert property (
    ##1 phase_done_out == (!$past(irdy_n_in)
                           && (!$past(trdy_n_out) || !$past(stop_n_out)))
  ) else $error("phase completion report does not follow the pins");

  chk_xfer_report: assert property (
    ##1 xfer_out == (!$past(irdy_n_in) && !$past(trdy_n_out))
  ) else $error("data transfer report does not follow irdy and trdy");

  chk_stop_hold: assert property (
    (!stop_n_out && !(phase_done && frame_n_in)) |=> !stop_n_out
  ) else $error("stop released before the last phase completed");

  chk_release_seq: assert property (
    (phase_done && frame_n_in)
      |=> (trdy_n_out && stop_n_out && devsel_n_out && !trdy_oe_n_out)
      ##1 (trdy_oe_n_out && stop_oe_n_out && devsel_oe_n_out)
  ) else $error("signals not deasserted then floated after last phase");

  chk_commit_hold: assert property (
    ((!trdy_n_out || !stop_n_out) && !phase_done)
      |=> $stable({devsel_n_out, trdy_n_out, stop_n_out})
  ) else $error("commitment changed before phase completion");

  chk_disc_data: assert property (
    (!trdy_n_out && !stop_n_out && phase_done && !frame_n_in)
      |=> (trdy_n_out && !stop_n_out) ##1 (!stop_n_out || end_valid_out)
  ) else $error("disconnect with data did not drop trdy and keep stop");

  chk_stop_cause: assert property (
    $fell(stop_n_out) |-> $past(take)
  ) else $error("stop asserted without an accepted answer");

  chk_abort_code: assert property (
    ($fell(stop_n_out) && devsel_n_out)
      |-> (trdy_n_out && !$past(devsel_n_out))
  ) else $error("abort encoding wrong or devsel not asserted before");

  chk_wait_none: assert property (
    (state == BTT_WAIT && !resp_valid_in) |=> (trdy_n_out && stop_n_out)
  ) else $error("commitment made while waiting with no answer");

  chk_after_disc: assert property (
    (state == BTT_STOPPING && phase_done && !frame_n_in)
      |=> (trdy_n_out && !stop_n_out && !xfer_out)
  ) else $error("dataless continuation phase misdriven");

  chk_fast_claim: assert property (
    (phase_done && frame_n_in && first && !trdy_n_out && !devsel_n_out)
      |=> (end_valid_out && end_kind_out == BTT_END_NORMAL)
  ) else $error("single phase completion reported as termination");

  chk_end_flag: assert property (
    end_valid_out |-> (abnormal_out == (end_kind_out == BTT_END_ABORT))
  ) else $error("abnormal flag disagrees with ending kind");

  chk_turn_quiet: assert property (
    (state == BTT_IDLE && claim_in && read_in)
      |=> (stop_n_out && trdy_n_out && !devsel_n_out) ##1 stop_n_out
  ) else $error("stop or trdy driven during read turnaround");

endmodule

`default_nettype wire

//--- btt_pkg.sv
package btt_pkg;

  localparam logic BTT_ON  = 1'b0;
  localparam logic BTT_OFF = 1'b1;

  typedef enum logic [2:0] {
    BTT_IDLE,
    BTT_TURN,
    BTT_WAIT,
    BTT_COMMIT,
    BTT_STOPPING,
    BTT_RELEASE
  } btt_state_t;

  // what the back end wants done with the current data phase
  typedef enum logic [1:0] {
    BTT_RESP_CONT,
    BTT_RESP_DISC_DATA,
    BTT_RESP_STOP,
    BTT_RESP_ABORT
  } btt_resp_t;

  typedef enum logic [1:0] {
    BTT_END_NORMAL,
    BTT_END_RETRY,
    BTT_END_DISC,
    BTT_END_ABORT
  } btt_end_t;

  typedef struct packed {
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
  } btt_drive_t;

  localparam btt_drive_t BTT_DRIVE_IDLE = '{
    devsel_n: BTT_OFF,
    trdy_n:   BTT_OFF,
    stop_n:   BTT_OFF
  };

endpackage

//--- btt_phase_mon.sv
`timescale 1ns/10ps
`default_nettype none

module btt_phase_mon (
  input  wire logic frame_n_in,
  input  wire logic irdy_n_in,
  input  wire logic trdy_n_in,
  input  wire logic stop_n_in,
  output var  logic done_out,
  output var  logic xfer_out,
  output var  logic last_out
);

  always_comb begin
    // all controls active low, judged at the rising edge
    done_out = !irdy_n_in && (!trdy_n_in || !stop_n_in);
    xfer_out = !irdy_n_in && !trdy_n_in;
    // frame high at completion marks the master's final phase
    last_out = done_out && frame_n_in;
  end

endmodule

`default_nettype wire

//--- btt_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module btt_master_model (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       go_in,
  input  wire logic [3:0] phases_in,
  input  wire logic       slow_in,
  input  wire logic       trdy_n_in,
  input  wire logic       stop_n_in,
  output var  logic       frame_n_out,
  output var  logic       irdy_n_out
);
  logic [1:0] st;
  logic [3:0] left;
  logic       stopped;
  logic       done;

  assign done = !irdy_n_out && (!trdy_n_in || !stop_n_in);

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= 2'h0;
      frame_n_out <= 1'b1;
      irdy_n_out <= 1'b1;
      left <= 4'h0;
      stopped <= 1'b0;
    end else begin
      case (st)
        2'h0: if (go_in) begin
          frame_n_out <= 1'b0;
          left <= phases_in;
          stopped <= 1'b0;
          st <= 2'h1;
        end
        2'h1: begin
          irdy_n_out <= 1'b0;
          frame_n_out <= (left == 4'h1);
          st <= 2'h2;
        end
        2'h2: if (done) begin
          if (frame_n_out) begin
            irdy_n_out <= 1'b1;
            st <= 2'h0;
          end else begin
            left <= left - 4'h1;
            stopped <= stopped | !stop_n_in;
            if (slow_in) begin
              irdy_n_out <= 1'b1;
              st <= 2'h3;
            end else begin
              frame_n_out <= !stop_n_in || stopped
                             || left == 4'h2;
            end
          end
        end
        default: begin
          // a wait state keeps frame low until irdy can be asserted again
          irdy_n_out <= 1'b0;
          // stop may have come up while irdy was held off
          frame_n_out <= !stop_n_in || stopped || left == 4'h1;
          st <= 2'h2;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

//--- btt_tb.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import btt_pkg::*;
  logic       sys_clk_in, rst_in, go, slow, claim, rd, rvalid, rdy;
  logic       frame_n, irdy_n, devsel_n, trdy_n, stop_n, xfer, pdone;
  logic       devsel_oe_n, trdy_oe_n, stop_oe_n, endv, abn;
  logic       devsel_w, trdy_w, stop_w;
  logic       plast, pplast, pstop, pcommit;
  logic [2:0] pdrv;
  logic [3:0] ph;
  logic [7:0] bxfer, bphase, dxfer, dphase, viol;
  btt_resp_t  rkind, rq1;
  btt_end_t   ekind;
  logic       second;
  int         failures, comparisons;

  // released target lines float high through the bus pull-ups
  assign devsel_w = devsel_oe_n ? 1'b1 : devsel_n;
  assign trdy_w = trdy_oe_n ? 1'b1 : trdy_n;
  assign stop_w = stop_oe_n ? 1'b1 : stop_n;

  btt_target DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .frame_n_in(frame_n), .irdy_n_in(irdy_n), .claim_in(claim),
    .read_in(rd), .resp_valid_in(rvalid), .resp_kind_in(rkind),
    .devsel_n_out(devsel_n), .devsel_oe_n_out(devsel_oe_n),
    .trdy_n_out(trdy_n), .trdy_oe_n_out(trdy_oe_n), .stop_n_out(stop_n),
    .stop_oe_n_out(stop_oe_n), .resp_ready_out(rdy), .xfer_out(xfer),
    .phase_done_out(pdone), .end_valid_out(endv), .end_kind_out(ekind),
    .abnormal_out(abn));

  btt_master_model master (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .go_in(go), .phases_in(ph), .slow_in(slow), .trdy_n_in(trdy_w),
    .stop_n_in(stop_w), .frame_n_out(frame_n), .irdy_n_out(irdy_n));

  always #5 sys_clk_in = ~sys_clk_in;

  // back end: one answer per data phase, held until taken
  always @(posedge sys_clk_in) begin
    if (rvalid && (rdy || (claim && !rd && rkind != BTT_RESP_ABORT))) begin
      if (second) begin
        rkind <= rq1;
        second <= 1'b0;
      end else begin
        rvalid <= 1'b0;
      end
    end
  end

  // bus monitor: counts on the wire and protocol hazards of the target
  always @(posedge sys_clk_in) begin
    bxfer = bxfer + 8'(!irdy_n && !trdy_w);
    bphase = bphase + 8'(!irdy_n && (!trdy_w || !stop_w));
    dxfer = dxfer + 8'(xfer);
    dphase = dphase + 8'(pdone);
    if (stop_w && !pstop && !plast) viol = viol + 8'h01;
    if (plast && !(devsel_w && trdy_w && stop_w)) begin
      viol = viol + 8'h01;
    end
    if (pplast && !(devsel_oe_n && trdy_oe_n && stop_oe_n)) begin
      viol = viol + 8'h01;
    end
    if (pcommit && {devsel_w, trdy_w, stop_w} !== pdrv) begin
      viol = viol + 8'h01;
    end
    pplast = plast;
    plast = !irdy_n && frame_n && (!trdy_w || !stop_w);
    pstop = stop_w;
    pcommit = (!trdy_w || !stop_w) && irdy_n;
    pdrv = {devsel_w, trdy_w, stop_w};
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic transact(input string nm, input logic r, input logic [3:0] p,
      input logic s, input btt_resp_t k0, input btt_resp_t k1,
      input logic two, input btt_end_t ek, input logic [7:0] ex,
      input logic [7:0] ep);
    int n;
    #1;
    {bxfer, bphase, dxfer, dphase, viol} = '0;
    rq1 = k1;
    second = two;
    @(posedge sys_clk_in);
    go <= 1'b1;
    rd <= r;
    ph <= p;
    slow <= s;
    @(posedge sys_clk_in);
    go <= 1'b0;
    claim <= 1'b1;
    rvalid <= 1'b1;
    rkind <= k0;
    @(posedge sys_clk_in);
    claim <= 1'b0;
    #1;
    if (r) begin
      chk({6'h0, trdy_w, stop_w}, 8'h03);
      chk({7'h0, rdy}, 8'h00);
      @(posedge sys_clk_in);
      #1;
      chk({7'h0, rdy}, 8'h01);
    end
    n = 0;
    while (endv !== 1'b1 && n < 60) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    // a transaction that never ends counts as a mismatch here
    chk({7'h0, endv}, 8'h01);
    chk({6'h0, ekind}, {6'h0, ek});
    chk({7'h0, abn}, {7'h0, ek == BTT_END_ABORT});
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk(bxfer, ex);
    chk(dxfer, ex);
    chk(bphase, ep);
    chk(dphase, ep);
    chk(viol, 8'h00);
    $display("test %s finished", nm);
  endtask

  task automatic test_retry;
    transact("retry", 0, 4'h4, 0, BTT_RESP_STOP, BTT_RESP_STOP, 0,
             BTT_END_RETRY, 8'h00, 8'h02);
  endtask

  task automatic test_disconnect;
    transact("disconnect", 0, 4'h4, 1, BTT_RESP_CONT, BTT_RESP_DISC_DATA, 1,
             BTT_END_DISC, 8'h02, 8'h03);
  endtask

  task automatic test_abort;
    transact("abort", 1, 4'h2, 0, BTT_RESP_ABORT, BTT_RESP_ABORT, 0,
             BTT_END_ABORT, 8'h00, 8'h02);
  endtask

  task automatic test_single_read;
    transact("single", 1, 4'h1, 0, BTT_RESP_DISC_DATA, BTT_RESP_CONT, 0,
             BTT_END_NORMAL, 8'h01, 8'h01);
  endtask

  task automatic test_repeat;
    transact("repeat", 0, 4'h2, 0, BTT_RESP_CONT, BTT_RESP_CONT, 1,
             BTT_END_NORMAL, 8'h02, 8'h02);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end

  initial begin
    {sys_clk_in, go, slow, claim, rd, rvalid, ph, second} = '0;
    rst_in = 1'b1;
    rkind = BTT_RESP_CONT;
    rq1 = BTT_RESP_CONT;
    {bxfer, bphase, dxfer, dphase, viol} = '0;
    {plast, pplast, pcommit} = '0;
    pstop = 1'b1;
    pdrv = 3'h7;
    failures = 0;
    comparisons = 0;
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    test_retry();
    test_disconnect();
    test_abort();
    test_repeat();
    test_single_read();
    tally_and_finish();
  end
endmodule

`default_nettype wire
